// [sensor_queue_port.sv]
// sensor sample queue with shadowed tally, data port and identity register
`timescale 1ns/1ps
`default_nettype none
module sensor_queue_port
    import sensor_queue_pkg::*;
#(
    parameter int         DEPTH      = DEPTH_DEFAULT,
    parameter logic [5:0] ADDR_UPPER = ADDR_UPPER_DEFAULT
)(
    input  wire logic                     REF_CLK,
    input  wire logic                     RST_N,
    input  wire host_req_t                HOST_REQ,
    output var  logic [7:0]               HOST_RDATA,
    input  wire logic                     SAMPLE_TICK,
    input  wire logic [NUM_SOURCES*8-1:0] SENSOR_DATA,
    input  wire logic [NUM_SOURCES-1:0]   SOURCE_ENABLE,
    input  wire logic                     QUEUE_ENABLE,
    input  wire logic                     FLUSH_REQ,
    input  wire logic                     OVERRUN_POLICY,
    input  wire logic                     OVERRUN_CLEAR,
    output var  logic                     QUEUE_OVERRUN_FLAG,
    output var  logic                     FLUSH_PENDING
);
    localparam int AW = $clog2(DEPTH);
    // one bit more than the pointers, so a full queue of DEPTH bytes is never taken for empty
    localparam int            CW       = AW + 1;
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [CW-1:0] CNT_ONE  = CW'(1);

    typedef struct packed {
        fill_state_t                   st;
        logic [$clog2(NUM_SOURCES):0]  src;
        logic [NUM_SOURCES*8-1:0]      snap;
        logic [NUM_SOURCES-1:0]        en;
        logic [AW-1:0]                 wp;
        logic [AW-1:0]                 rp;
        logic [CW-1:0]                 cnt;
        logic [COUNT_W-1:0]            shadow;
        logic [7:0]                    rdata;
        logic                          ovf;
        logic                          flush;
    } state_t;

    state_t     s_q;
    state_t     s_d;
    logic [7:0] mem [DEPTH];
    logic       push;
    logic [7:0] push_byte;
    logic       pop;
    logic       mem_we;
    logic [AW-1:0] mem_wa;
    logic          ovf_set;
    logic [COUNT_W-1:0] live_tally;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    // the register field stays ten bits whatever the depth; a full 1024 deep queue reads as zero
    function automatic logic [COUNT_W-1:0] tally_of(input logic [CW-1:0] c);
        tally_of = COUNT_W'(c);
    endfunction

    always_comb
    begin
        s_d       = s_q;
        push      = 1'b0;
        pop       = 1'b0;
        push_byte = s_q.snap[s_q.src[$clog2(NUM_SOURCES)-1:0]*8 +: 8];
        mem_we    = 1'b0;
        mem_wa    = s_q.wp;
        ovf_set   = 1'b0;
        if (FLUSH_REQ)
        begin
            s_d.flush = 1'b1;
        end
        case (s_q.st)
            FILL_IDLE:
            begin
                if (SAMPLE_TICK && (SOURCE_ENABLE != '0))
                begin
                    s_d.snap = SENSOR_DATA;
                    s_d.en   = SOURCE_ENABLE;
                    s_d.src  = '0;
                    s_d.st   = FILL_SCAN;
                end
            end
            FILL_SCAN:
            begin
                // ascending source order, one source per clock; a disabled source takes its clock but pushes no byte
                if (s_q.en[s_q.src[$clog2(NUM_SOURCES)-1:0]])
                begin
                    push = 1'b1;
                end
                if (s_q.src == ($clog2(NUM_SOURCES)+1)'(NUM_SOURCES - 1))
                begin
                    s_d.st = FILL_IDLE;
                end
                s_d.src = s_q.src + 1'b1;
            end
            default:
            begin
                s_d.st = FILL_IDLE;
            end
        endcase
        if (HOST_REQ.wr && HOST_REQ.addr == ADDR_DATA_PORT)
        begin
            // host writes through the same data port
            push      = 1'b1;
            push_byte = HOST_REQ.wdata;
        end
        // reads blocked while disabled; empty reads return zero
        if (HOST_REQ.rd && HOST_REQ.addr == ADDR_DATA_PORT && QUEUE_ENABLE && s_q.cnt != '0)
        begin
            pop = 1'b1;
        end
        s_d.rdata = 8'h00;
        if (HOST_REQ.rd)
        begin
            case (HOST_REQ.addr)
                ADDR_TALLY_HIGH:
                begin
                    s_d.shadow = live_tally;
                    s_d.rdata  = {6'h00, live_tally[COUNT_W-1:TALLY_HI_LSB]};
                end
                ADDR_TALLY_LOW:
                begin
                    s_d.rdata = s_q.shadow[7:0];
                end
                ADDR_DATA_PORT:
                begin
                    s_d.rdata = pop ? mem[s_q.rp] : 8'h00;
                end
                ADDR_IDENTITY:
                begin
                    // pin level never enters
                    s_d.rdata = {1'b0, ADDR_UPPER, 1'b0};
                end
                default:
                begin
                    s_d.rdata = 8'h00;
                end
            endcase
        end
        if (pop)
        begin
            s_d.rp = ptr_inc(s_q.rp);
        end
        if (push)
        begin
            if (s_q.cnt == CNT_FULL && !pop)
            begin
                ovf_set = 1'b1;
                if (OVERRUN_POLICY)
                begin
                    // policy one: drop the new byte, keep the old contents
                end
                else
                begin
                    // policy zero: overwrite the oldest byte
                    mem_we = 1'b1;
                    s_d.wp = ptr_inc(s_q.wp);
                    s_d.rp = ptr_inc(s_q.rp);
                end
            end
            else
            begin
                mem_we = 1'b1;
                s_d.wp = ptr_inc(s_q.wp);
            end
        end
        // tally tracks stored bytes
        if (mem_we && !pop && s_q.cnt != CNT_FULL)
        begin
            s_d.cnt = s_q.cnt + CNT_ONE;
        end
        else if (pop && !mem_we)
        begin
            s_d.cnt = s_q.cnt - CNT_ONE;
        end
        // the flag's set wins over the host clear, even when the flag already stands
        if (ovf_set)
        begin
            s_d.ovf = 1'b1;
        end
        else if (OVERRUN_CLEAR)
        begin
            s_d.ovf = 1'b0;
        end
        if (s_q.flush)
        begin
            // flush empties the queue and drops this cycle's write; a data read in this cycle still returns its byte
            s_d.wp    = '0;
            s_d.rp    = '0;
            s_d.cnt   = '0;
            // a request landing in the flush cycle is kept, not lost
            s_d.flush = FLUSH_REQ;
            mem_we    = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (mem_we)
        begin
            mem[mem_wa] <= push_byte;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign HOST_RDATA         = s_q.rdata;
    assign QUEUE_OVERRUN_FLAG = s_q.ovf;
    assign FLUSH_PENDING      = s_q.flush;
    assign live_tally         = tally_of(s_q.cnt);

    AST_HIGH_LOADS_SHADOW: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (HOST_REQ.rd && HOST_REQ.addr == ADDR_TALLY_HIGH) |=> (s_q.shadow == $past(live_tally)))
        else $error("shadow not loaded on high read");
    AST_LOW_KEEPS_SHADOW: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        !(HOST_REQ.rd && HOST_REQ.addr == ADDR_TALLY_HIGH) |=> $stable(s_q.shadow))
        else $error("shadow changed without high read");
    AST_HIGH_FORMAT: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (HOST_REQ.rd && HOST_REQ.addr == ADDR_TALLY_HIGH)
        |=> HOST_RDATA == {6'h00, $past(live_tally[9:8])})
        else $error("tally high format wrong");
    AST_IDENTITY: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (HOST_REQ.rd && HOST_REQ.addr == ADDR_IDENTITY) |=> HOST_RDATA == {1'b0, ADDR_UPPER, 1'b0})
        else $error("identity value wrong");
    AST_DISABLED_NO_POP: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (!QUEUE_ENABLE && !push && !s_q.flush) |=> s_q.cnt >= $past(s_q.cnt))
        else $error("tally fell while disabled");
    AST_POP_DECREMENTS: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (pop && !push && !s_q.flush) |=> s_q.cnt == $past(s_q.cnt) - CNT_ONE)
        else $error("pop did not decrement");
    AST_OVERRUN_SETS: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (push && !pop && s_q.cnt == CNT_FULL) |=> s_q.ovf)
        else $error("overrun flag not set");
    AST_COUNT_BOUNDED: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        s_q.cnt <= CNT_FULL)
        else $error("tally above queue depth");
    AST_FLUSH_EMPTIES: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        FLUSH_REQ |=> s_q.flush ##1 (s_q.cnt == '0 && s_q.flush == $past(FLUSH_REQ)))
        else $error("flush did not empty queue");
    AST_DISABLED_SOURCE_SKIPPED: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (s_q.st == FILL_SCAN && !s_q.en[s_q.src[2:0]] && !HOST_REQ.wr) |-> !push)
        else $error("disabled source pushed");

    COV_FULL_SET: cover property (@(posedge REF_CLK) disable iff (!RST_N)
        SAMPLE_TICK && SOURCE_ENABLE == 8'hFF ##9 live_tally == 10'h008);
    COV_OVERRUN: cover property (@(posedge REF_CLK) disable iff (!RST_N) $rose(s_q.ovf));
    COV_HIGH_LOW: cover property (@(posedge REF_CLK) disable iff (!RST_N)
        (HOST_REQ.rd && HOST_REQ.addr == ADDR_TALLY_HIGH) ##1 (HOST_REQ.rd && HOST_REQ.addr == ADDR_TALLY_LOW));
    COV_FLUSH: cover property (@(posedge REF_CLK) disable iff (!RST_N) FLUSH_REQ);
endmodule // sensor_queue_port
`default_nettype wire

// [sensor_queue_pkg.sv]
// constants, types and register map for the sensor sample queue port
package sensor_queue_pkg;
    localparam logic [7:0] ADDR_TALLY_HIGH = 8'h72;
    localparam logic [7:0] ADDR_TALLY_LOW  = 8'h73;
    localparam logic [7:0] ADDR_DATA_PORT  = 8'h74;
    localparam logic [7:0] ADDR_IDENTITY   = 8'h75;
    localparam int         DEPTH_DEFAULT   = 1024;
    localparam int         NUM_SOURCES     = 8;
    localparam int         COUNT_W         = 10;
    localparam int         TALLY_HI_LSB    = 8;
    localparam int         ID_LSB          = 1;
    // arbitrary neutral value, not any real part's address
    localparam logic [5:0] ADDR_UPPER_DEFAULT = 6'h15;
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 10'h000;

    typedef enum logic [1:0] {
        FILL_IDLE,
        FILL_SCAN
    } fill_state_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_t;
endpackage

// [host_model.sv]
// host processor model issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module host_model
    import sensor_queue_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    output var  host_req_t  req
);
    initial req = '0;
    // one pulse per access and an idle cycle after it, so no edge sees two requests
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        #1 req = '{rd: !w, wr: w, addr: a, wdata: d};
        @(posedge clk);
        #1 q = rdata;
        req = '0;
    endtask
endmodule // host_model
`default_nettype wire

// [sensor_queue_port_tb.sv]
// self-checking bench for the sensor sample queue port
`timescale 1ns/1ps
`default_nettype none
module sensor_queue_port_tb;
    import sensor_queue_pkg::*;
    localparam int         DEP   = 16;
    localparam logic [5:0] UPPER = 6'h2D; // arbitrary value
    logic        clk    = 1'b0;
    logic        rst_n  = 1'b0;
    logic        tick   = 1'b0;
    logic        flush  = 1'b0;
    logic        policy = 1'b0;
    logic        oclr   = 1'b0;
    logic        qen    = 1'b1;
    logic [63:0] sdata  = '0;
    logic [7:0]  sen    = '0;
    logic [31:0] seed   = 32'h25;
    host_req_t   req;
    logic [7:0]  rdata;
    logic [7:0]  q;
    logic        oflag;
    logic        fpend;
    logic [7:0]  mq[$];
    int          miscompares = 0;
    int          n_checks    = 0;
    always #2.5 clk = ~clk;
    host_model hm (.clk(clk), .rdata(rdata), .req(req));
    sensor_queue_port #(.DEPTH(DEP), .ADDR_UPPER(UPPER)) dut (.REF_CLK(clk), .RST_N(rst_n), .HOST_REQ(req),
        .HOST_RDATA(rdata), .SAMPLE_TICK(tick), .SENSOR_DATA(sdata), .SOURCE_ENABLE(sen), .QUEUE_ENABLE(qen),
        .FLUSH_REQ(flush), .OVERRUN_POLICY(policy), .OVERRUN_CLEAR(oclr), .QUEUE_OVERRUN_FLAG(oflag),
        .FLUSH_PENDING(fpend));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // expected queue: policy 1 drops the new byte, policy 0 loses the oldest
    function automatic void push_model(input logic [7:0] b);
        if (mq.size() == DEP && policy)
            return;
        if (mq.size() == DEP)
            void'(mq.pop_front());
        mq.push_back(b);
    endfunction
    task automatic close_out();
        if (miscompares == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        hm.access(1'b1, a, d, q);
        if (a == ADDR_DATA_PORT)
            push_model(d);
    endtask
    task automatic rd(input logic [7:0] a);
        hm.access(1'b0, a, 8'h00, q);
    endtask
    task automatic tally();
        logic [7:0] h;
        hm.access(1'b0, ADDR_TALLY_HIGH, 8'h00, h);
        rd(ADDR_TALLY_LOW);
        check("tally", {h, q}, 16'(mq.size()));
    endtask
    task automatic drain();
        int n;
        n = mq.size(); // never read past the tally
        repeat (n)
        begin
            rd(ADDR_DATA_PORT);
            check("data", q, mq.pop_front());
        end
        tally();
    endtask
    task automatic sample(input logic [7:0] en);
        @(posedge clk);
        #1 sen = en;
        sdata = {rnd(), rnd()};
        tick = 1'b1;
        @(posedge clk);
        #1 tick = 1'b0;
        for (int i = 0; i < 8; i++)
            if (en[i])
                push_model(sdata[8*i +: 8]);
        repeat (10) @(posedge clk);
    endtask
    task automatic pulse_clr();
        @(posedge clk);
        #1 oclr = 1'b1;
        @(posedge clk);
        #1 oclr = 1'b0;
    endtask
    initial
    begin
        #200000;
        miscompares++;
        close_out();
    end
    initial
    begin
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        wr(ADDR_IDENTITY, 8'hFF);
        rd(ADDR_IDENTITY);
        check("identity", q, {1'b0, UPPER, 1'b0});
        tally();
        for (int k = 0; k < 5; k++)
            wr(ADDR_DATA_PORT, 8'(rnd()));
        tally();
        wr(ADDR_DATA_PORT, 8'h5A);
        rd(ADDR_TALLY_LOW);
        check("stale low", q, 8'h05);
        tally();
        drain();
        rd(ADDR_DATA_PORT);
        check("empty read", q, 8'h00);
        sample(8'hFF);
        sample(8'(rnd()));
        tally();
        drain();
        // reads blocked while disabled, yet samples still land and are kept
        #1 qen = 1'b0;
        sample(8'hA5);
        rd(ADDR_DATA_PORT);
        check("blocked read", q, 8'h00);
        tally();
        qen = 1'b1;
        drain();
        for (int p = 1; p >= 0; p--)
        begin
            policy = p[0];
            #1 check("flag clear", oflag, 1'b0);
            repeat (DEP + 2)
                wr(ADDR_DATA_PORT, 8'(rnd()));
            @(posedge clk);
            #1 check("overrun", oflag, 1'b1);
            tally();
            drain();
            pulse_clr();
            @(posedge clk);
        end
        for (int k = 0; k < 3; k++)
            wr(ADDR_DATA_PORT, 8'(rnd()));
        @(posedge clk);
        #1 flush = 1'b1;
        @(posedge clk);
        #1 flush = 1'b0;
        check("flush pending", fpend, 1'b1);
        mq.delete();
        @(posedge clk);
        #1 check("flush done", fpend, 1'b0);
        tally();
        close_out();
    end
endmodule // sensor_queue_port_tb
`default_nettype wire
